//--- rtl/adc_pkg.sv
package adc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_ONE = 6'h0e;
  localparam logic [5:0] IDX_CTRL_TWO = 6'h0f;
  localparam logic [5:0] IDX_RES_LOW  = 6'h26;
  localparam logic [5:0] IDX_RES_UP   = 6'h27;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
  localparam logic [5:0] IDX_AUX      = 6'h32;

  // reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h10;
  localparam logic [5:0] CTRL_TWO_RST = 6'h00;

  // field positions, control one
  localparam int unsigned START_BIT = 7;
  localparam int unsigned MODE_HI   = 6;
  localparam int unsigned MODE_LO   = 5;
  localparam int unsigned AIN_BIT   = 4;
  localparam int unsigned CHAN_HI   = 3;
  // field positions, control two
  localparam int unsigned CTWO_HI    = 5;
  localparam int unsigned LADDER_BIT = 5;
  localparam int unsigned TIME_HI    = 3;
  localparam int unsigned TIME_LO    = 1;
  // field positions, lower result and status
  localparam int unsigned DONE_BIT = 5;
  localparam int unsigned BUSY_BIT = 4;
  // field positions, own registers
  localparam int unsigned DIV_BIT   = 0;
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_ABORT = 1;

  // converter shape
  localparam int unsigned RES_W = 10;
  localparam int unsigned CNT_W = 12;
  localparam logic [1:0]  BIT_CYC = 2'h3;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SOFT   = 2'b01,
    MODE_RSVD   = 2'b10,
    MODE_REPEAT = 2'b11
  } mode_type;

  // conversion times in oscillator cycles
  localparam logic [11:0] CYC_39   = 12'h027;
  localparam logic [11:0] CYC_78   = 12'h04e;
  localparam logic [11:0] CYC_156  = 12'h09c;
  localparam logic [11:0] CYC_312  = 12'h138;
  localparam logic [11:0] CYC_624  = 12'h270;
  localparam logic [11:0] CYC_1248 = 12'h4e0;
  localparam logic [11:0] CYC_2096 = 12'h830;

  // time code to cycle count; reserved codes take the longest time
  function automatic logic [11:0] conv_cycles(input logic [2:0] code, input logic div);
    logic [11:0] c;
    c = div ? CYC_2096 : CYC_1248;
    case (code)
      3'b000: c = CYC_39;
      3'b010: c = div ? CYC_156 : CYC_78;
      3'b011: c = div ? CYC_312 : CYC_156;
      3'b100: c = div ? CYC_624 : CYC_312;
      3'b101: c = div ? CYC_1248 : CYC_624;
      3'b110: c = div ? CYC_2096 : CYC_1248;
      default: c = div ? CYC_2096 : CYC_1248;
    endcase
    return c;
  endfunction

endpackage

//--- rtl/adc_irq.sv
`timescale 1ns/1ps
`default_nettype none
module adc_irq #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] event_set,
  input  wire logic         wr_status,
  input  wire logic         wr_mask,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);

  logic [W-1:0] status_r;
  logic [W-1:0] mask_r;

  // sticky status, write one clears, a new event wins
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(wr_status ? wdata : '0)) | event_set;
    end
  end

  // mask, one enables the bit
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= wdata;
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irq    = |(status_r & mask_r);

endmodule
`default_nettype wire

//--- rtl/adc_sar_seq.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sar_seq #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned CNT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] total,
  input  wire logic             comp_hi,
  output logic                  busy,
  output logic                  sample,
  output logic                  done,
  output logic      [RES_W-1:0] code,
  output logic      [RES_W-1:0] result
);

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_DECIDE} seq_state_type;

  localparam logic [CNT_W-1:0] DEC_CYC = CNT_W'(RES_W * adc_pkg::BIT_CYC);
  localparam logic [3:0]       MSB     = 4'(RES_W - 1);

  seq_state_type    state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0]       sub_r;
  logic [3:0]       idx_r;
  logic [RES_W-1:0] code_r;
  logic [RES_W-1:0] kept_nxt;
  logic [RES_W-1:0] result_r;
  logic             done_r;

  // trial bit kept when input is at or above the ladder level
  always_comb begin
    kept_nxt = code_r;
    if (!comp_hi) begin
      kept_nxt[idx_r] = 1'b0;
    end
  end

  // sample phase, then one bit every few cycles, msb first
  always_ff @(posedge clk) begin
    done_r <= 1'b0;
    if (rst || abort) begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
      sub_r   <= '0;
      idx_r   <= MSB;
      code_r  <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start) begin
            state_r       <= S_SAMPLE;
            cnt_r         <= CNT_W'(1);
            idx_r         <= MSB;
            code_r        <= '0;
            code_r[MSB]   <= 1'b1;
          end
        end
        S_SAMPLE: begin
          cnt_r <= cnt_r + CNT_W'(1);
          sub_r <= '0;
          if (cnt_r >= total - DEC_CYC) begin
            state_r <= S_DECIDE;
          end
        end
        S_DECIDE: begin
          cnt_r <= cnt_r + CNT_W'(1);
          sub_r <= sub_r + 2'h1;
          if (sub_r == adc_pkg::BIT_CYC - 2'h1) begin
            sub_r  <= '0;
            code_r <= kept_nxt;
            if (idx_r != 4'h0) begin
              code_r[idx_r - 4'h1] <= 1'b1;
              idx_r                <= idx_r - 4'h1;
            end else begin
              state_r <= S_IDLE;
              done_r  <= 1'b1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // result holds until the next completed conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= '0;
    end else if (state_r == S_DECIDE && idx_r == 4'h0 && sub_r == adc_pkg::BIT_CYC - 2'h1
                 && !abort) begin
      result_r <= kept_nxt;
    end
  end

  assign busy   = (state_r != S_IDLE);
  assign sample = (state_r == S_SAMPLE);
  assign done   = done_r;
  assign code   = code_r;
  assign result = result_r;

endmodule
`default_nettype wire

//--- rtl/adc_ctrl_top.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_top (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // classic wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             IRQ,
  // analog front end
  input  wire logic        COMP_IN,
  input  wire logic        LOW_POWER,
  output logic      [3:0]  CHANNEL,
  output logic             ANALOG_IN_DISABLE,
  output logic      [9:0]  LADDER_CODE,
  output logic             SAMPLE_HOLD,
  output logic             LADDER_CONNECT,
  output logic             BUSY
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int unsigned RES_W = adc_pkg::RES_W;
  localparam int unsigned CNT_W = adc_pkg::CNT_W;

  logic [1:0]  comp_sync_r;
  logic [1:0]  lp_sync_r;
  logic        comp_hi;
  logic        low_power;

  logic        ack_r;
  logic [31:0] dat_o_r;
  logic        req;
  logic        act;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;

  logic              conv_start_bit_r;
  adc_pkg::mode_type operating_mode_field_r;
  logic              analog_input_disable_r;
  logic [3:0]        channel_select_r;
  logic [5:0]        ctrl_two_r;
  logic              clock_divider_select_r;
  logic              conversion_done_flag_r;

  logic              mode_run;
  logic              abort;
  logic              seq_start;
  logic              converter_busy_flag;
  logic              seq_sample;
  logic              seq_done;
  logic [RES_W-1:0]  seq_code;
  logic [RES_W-1:0]  seq_result;
  logic [CNT_W-1:0]  conv_total;
  logic [adc_pkg::IRQ_W-1:0] irq_set;
  logic [adc_pkg::IRQ_W-1:0] irq_status;
  logic [adc_pkg::IRQ_W-1:0] irq_mask;
  logic              conversion_done_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // comparator and power state come from outside the clock domain
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      comp_sync_r <= 2'b00;
      lp_sync_r   <= 2'b00;
    end else begin
      comp_sync_r <= {comp_sync_r[0], COMP_IN};
      lp_sync_r   <= {lp_sync_r[0], LOW_POWER};
    end
  end

  assign comp_hi   = comp_sync_r[1];
  assign low_power = lp_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  // one wait state; access acts at the edge that samples ack
  assign req = CYC_I && STB_I;
  assign act = req && ack_r;
  assign wr  = act && WE_I && SEL_I[0];
  assign rd  = act && !WE_I;
  assign idx = ADR_I[7:2];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // read data captured one edge before ack is sampled
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dat_o_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      dat_o_r <= 32'h0000_0000;
      case (idx)
        adc_pkg::IDX_CTRL_ONE: dat_o_r[7:0] <= {conv_start_bit_r, operating_mode_field_r,
                                                analog_input_disable_r, channel_select_r};
        adc_pkg::IDX_CTRL_TWO: dat_o_r[5:0] <= ctrl_two_r;
        adc_pkg::IDX_RES_UP:   dat_o_r[7:0] <= seq_result[RES_W-1:2];
        adc_pkg::IDX_RES_LOW: begin
          dat_o_r[7:6]               <= seq_result[1:0];
          dat_o_r[adc_pkg::DONE_BIT] <= conversion_done_flag_r;
          dat_o_r[adc_pkg::BUSY_BIT] <= converter_busy_flag;
        end
        adc_pkg::IDX_IRQ_STAT: dat_o_r[adc_pkg::IRQ_W-1:0] <= irq_status;
        adc_pkg::IDX_IRQ_MASK: dat_o_r[adc_pkg::IRQ_W-1:0] <= irq_mask;
        adc_pkg::IDX_AUX:      dat_o_r[adc_pkg::DIV_BIT]   <= clock_divider_select_r;
        default:               dat_o_r <= 32'h0000_0000;
      endcase
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_o_r;

  ////////////////////////////////////////////////////////////////////////////////
  // control register one

  // fields reset and lock while in a low-power state
  always_ff @(posedge CLOCK) begin
    if (RST || low_power) begin
      operating_mode_field_r <= adc_pkg::mode_type'(adc_pkg::CTRL_ONE_RST[adc_pkg::MODE_HI:
                                                                           adc_pkg::MODE_LO]);
      analog_input_disable_r <= adc_pkg::CTRL_ONE_RST[adc_pkg::AIN_BIT];
      channel_select_r       <= adc_pkg::CTRL_ONE_RST[adc_pkg::CHAN_HI:0];
    end else if (wr && idx == adc_pkg::IDX_CTRL_ONE) begin
      operating_mode_field_r <= adc_pkg::mode_type'(DAT_I[adc_pkg::MODE_HI:adc_pkg::MODE_LO]);
      analog_input_disable_r <= DAT_I[adc_pkg::AIN_BIT];
      channel_select_r       <= DAT_I[adc_pkg::CHAN_HI:0];
    end
  end

  // start bit clears itself the cycle after it is set
  always_ff @(posedge CLOCK) begin
    if (RST || low_power) begin
      conv_start_bit_r <= adc_pkg::CTRL_ONE_RST[adc_pkg::START_BIT];
    end else if (wr && idx == adc_pkg::IDX_CTRL_ONE) begin
      conv_start_bit_r <= DAT_I[adc_pkg::START_BIT];
    end else begin
      conv_start_bit_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register two and own control

  // bits 5..0 stored as written, top bits not held
  always_ff @(posedge CLOCK) begin
    if (RST || low_power) begin
      ctrl_two_r <= adc_pkg::CTRL_TWO_RST;
    end else if (wr && idx == adc_pkg::IDX_CTRL_TWO) begin
      ctrl_two_r <= DAT_I[adc_pkg::CTWO_HI:0];
    end
  end

  // divider select for the conversion time table
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      clock_divider_select_r <= 1'b0;
    end else if (wr && idx == adc_pkg::IDX_AUX) begin
      clock_divider_select_r <= DAT_I[adc_pkg::DIV_BIT];
    end
  end

  // cycle count from time code and divider
  assign conv_total = adc_pkg::conv_cycles(ctrl_two_r[adc_pkg::TIME_HI:adc_pkg::TIME_LO],
                                           clock_divider_select_r);

  ////////////////////////////////////////////////////////////////////////////////
  // conversion control

  // only software start and repeat modes may run
  assign mode_run = (operating_mode_field_r == adc_pkg::MODE_SOFT) ||
                    (operating_mode_field_r == adc_pkg::MODE_REPEAT);

  // disabled or reserved mode, or low power, stops at once
  assign abort = low_power || !mode_run;

  // start on the start bit, or again after each repeat result
  assign seq_start = mode_run && !converter_busy_flag &&
                     (conv_start_bit_r ||
                      (seq_done && operating_mode_field_r == adc_pkg::MODE_REPEAT));

  adc_sar_seq #(
    .RES_W (RES_W),
    .CNT_W (CNT_W)
  ) u_seq (
    .clk     (CLOCK),
    .rst     (RST),
    .start   (seq_start),
    .abort   (abort),
    .total   (conv_total),
    .comp_hi (comp_hi),
    .busy    (converter_busy_flag),
    .sample  (seq_sample),
    .done    (seq_done),
    .code    (seq_code),
    .result  (seq_result)
  );

  // done flag: set wins over clears by upper read or restart
  always_ff @(posedge CLOCK) begin
    if (RST || low_power) begin
      conversion_done_flag_r <= 1'b0;
    end else if (seq_done && !abort) begin
      conversion_done_flag_r <= 1'b1;
    end else if ((rd && idx == adc_pkg::IDX_RES_UP) || seq_start) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts

  // completion and forced stop of a running conversion
  always_comb begin
    irq_set                     = '0;
    irq_set[adc_pkg::IRQ_DONE]  = seq_done && !abort;
    irq_set[adc_pkg::IRQ_ABORT] = converter_busy_flag && abort;
  end

  adc_irq #(
    .W (adc_pkg::IRQ_W)
  ) u_irq (
    .clk       (CLOCK),
    .rst       (RST),
    .event_set (irq_set),
    .wr_status (wr && idx == adc_pkg::IDX_IRQ_STAT),
    .wr_mask   (wr && idx == adc_pkg::IDX_IRQ_MASK),
    .wdata     (DAT_I[adc_pkg::IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (conversion_done_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign IRQ               = conversion_done_irq;
  assign CHANNEL           = channel_select_r;
  assign ANALOG_IN_DISABLE = analog_input_disable_r;
  assign LADDER_CODE       = seq_code;
  assign SAMPLE_HOLD       = seq_sample;
  assign BUSY              = converter_busy_flag;
  // ladder always on or only while converting
  assign LADDER_CONNECT    = ctrl_two_r[adc_pkg::LADDER_BIT] || converter_busy_flag;

endmodule
`default_nettype wire

//--- testbench/adc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        LOW_POWER,
  input wire logic [3:0]  CHANNEL,
  input wire logic        ANALOG_IN_DISABLE,
  input wire logic [9:0]  LADDER_CODE,
  input wire logic        SAMPLE_HOLD,
  input wire logic        LADDER_CONNECT,
  input wire logic        BUSY
);
  logic [3:0] lp_hist_r;
  // low-power history; writes count only once the synchroniser is clear
  always_ff @(posedge CLOCK) begin
    lp_hist_r <= RST ? 4'h0 : {lp_hist_r[2:0], LOW_POWER};
  end
  wire logic wr_one = ACK_O && WE_I && SEL_I[0] && !LOW_POWER && lp_hist_r == 4'h0
                      && ADR_I[7:2] == adc_pkg::IDX_CTRL_ONE;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // start write, then sample phase with the msb trial code on the ladder
  sequence s_start_wr;
    wr_one && DAT_I[7] && DAT_I[5] && !BUSY;
  endsequence
  sequence s_conv_begin;
    BUSY && SAMPLE_HOLD && LADDER_CODE == 10'h200;
  endsequence

  AST_ACK_ANSWER: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_NO_STRAY_ACK: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  AST_START: assert property (s_start_wr |-> ##2 s_conv_begin)
    else $error("conversion did not begin after start write");
  AST_STOP: assert property (wr_one && !DAT_I[5] |-> ##2 !BUSY)
    else $error("busy after disabled or reserved mode write");
  AST_LADDER: assert property (BUSY |-> LADDER_CONNECT)
    else $error("ladder not connected while converting");
  AST_SH_IN_BUSY: assert property (SAMPLE_HOLD |-> BUSY)
    else $error("sample phase outside conversion");
  AST_BIT_HOLD: assert property ((BUSY && !SAMPLE_HOLD && $changed(LADDER_CODE)) ##1 BUSY
                                 |-> $stable(LADDER_CODE))
    else $error("trial code not held");
  AST_LP_CLEAR: assert property (LOW_POWER [*5] |-> !BUSY && !LADDER_CONNECT
                                 && ANALOG_IN_DISABLE && CHANNEL == 4'h0)
    else $error("low power did not reinitialise");
  AST_RD_HIGH_ZERO: assert property (ACK_O |-> DAT_O[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
endmodule

bind adc_ctrl_top adc_ctrl_checker chk (
  .CLOCK(CLOCK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LOW_POWER(LOW_POWER),
  .CHANNEL(CHANNEL), .ANALOG_IN_DISABLE(ANALOG_IN_DISABLE), .LADDER_CODE(LADDER_CODE),
  .SAMPLE_HOLD(SAMPLE_HOLD), .LADDER_CONNECT(LADDER_CONNECT), .BUSY(BUSY)
);
`default_nettype wire

//--- testbench/adc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input  wire logic       clk,
  input  wire logic [9:0] level,
  input  wire logic       sample_hold,
  input  wire logic       ain_disable,
  input  wire logic [9:0] ladder_code,
  output logic            comp_hi
);
  logic [9:0] held_r = 10'h000;
  // hold capacitor follows the input only in the sample phase
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held_r <= ain_disable ? 10'h000 : level;
    end
  end
  // comparator against the ladder trial level
  assign comp_hi = held_r >= ladder_code;
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CLOCK, RST, CYC_I, STB_I, WE_I, LOW_POWER, ACK_O, IRQ, COMP_IN;
  logic        SAMPLE_HOLD, LADDER_CONNECT, BUSY, ANALOG_IN_DISABLE;
  logic [7:0]  ADR_I;
  logic [3:0]  SEL_I, CHANNEL;
  logic [31:0] DAT_I, DAT_O, rd;
  logic [9:0]  LADDER_CODE, level;
  int          mismatches = 0, cmp_count = 0, cnt;

  // 20 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  adc_ctrl_top uut (.CLOCK(CLOCK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ),
    .COMP_IN(COMP_IN), .LOW_POWER(LOW_POWER), .CHANNEL(CHANNEL), .BUSY(BUSY),
    .ANALOG_IN_DISABLE(ANALOG_IN_DISABLE), .LADDER_CODE(LADDER_CODE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .LADDER_CONNECT(LADDER_CONNECT));
  adc_front_model front (.clk(CLOCK), .level(level), .sample_hold(SAMPLE_HOLD),
    .ain_disable(ANALOG_IN_DISABLE), .ladder_code(LADDER_CODE), .comp_hi(COMP_IN));
  ////////////////////////////////////////////////////////////////////////////
  // shared compare, bus cycle and busy wait
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= {idx, 2'b00};
    DAT_I <= {24'h00_0000, d};
    do begin
      @(posedge CLOCK);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(negedge CLOCK);
  endtask
  task automatic wait_busy(input logic v);
    cnt = 0;
    while (BUSY !== v && cnt < 3000) begin
      @(negedge CLOCK);
      cnt++;
    end
    if (cnt >= 3000) mismatches++;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    wb(0, adc_pkg::IDX_CTRL_ONE, 8'h00);
    chk(rd, 32'h0000_0010);
    SEL_I <= 4'h0;
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h0b);
    SEL_I <= 4'h1;
    wb(0, adc_pkg::IDX_CTRL_ONE, 8'h00);
    chk(rd, 32'h0000_0010);
    wb(0, adc_pkg::IDX_CTRL_TWO, 8'h00);
    chk(rd & 32'h0000_003f, 32'h0000_0000);
    wb(1, 6'h01, 8'hff);
    wb(0, 6'h01, 8'h00);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_ctrl;
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h0b);
    chk(32'({ANALOG_IN_DISABLE, CHANNEL}), 32'h0000_000b);
    wb(1, adc_pkg::IDX_CTRL_TWO, 8'h30);
    chk(32'(LADDER_CONNECT), 32'h0000_0001);
    wb(0, adc_pkg::IDX_CTRL_TWO, 8'h00);
    chk(rd & 32'h0000_003f, 32'h0000_0030);
    wb(1, adc_pkg::IDX_CTRL_TWO, 8'h10);
    chk(32'(LADDER_CONNECT), 32'h0000_0000);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h10);
    chk(32'(ANALOG_IN_DISABLE), 32'h0000_0001);
    $display("control test done");
  endtask
  task automatic t_times;
    logic [11:0] tab [2][8];
    tab = '{'{adc_pkg::CYC_39, adc_pkg::CYC_1248, adc_pkg::CYC_78, adc_pkg::CYC_156,
              adc_pkg::CYC_312, adc_pkg::CYC_624, adc_pkg::CYC_1248, adc_pkg::CYC_1248},
            '{adc_pkg::CYC_39, adc_pkg::CYC_2096, adc_pkg::CYC_156, adc_pkg::CYC_312,
              adc_pkg::CYC_624, adc_pkg::CYC_1248, adc_pkg::CYC_2096, adc_pkg::CYC_2096}};
    for (int d = 0; d < 2; d++) begin
      wb(1, adc_pkg::IDX_AUX, 8'(d));
      for (int c = 0; c < 8; c++) begin
        wb(1, adc_pkg::IDX_CTRL_TWO, 8'h10 | 8'(c << 1));
        wb(1, adc_pkg::IDX_CTRL_ONE, 8'ha0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(32'(cnt), 32'(tab[d][c]));
      end
    end
    wb(1, adc_pkg::IDX_AUX, 8'h00);
    $display("timing test done");
  endtask
  task automatic t_irq;
    wb(1, adc_pkg::IDX_IRQ_MASK, 8'h00);
    wb(1, adc_pkg::IDX_IRQ_STAT, 8'h03);
    wb(1, adc_pkg::IDX_CTRL_TWO, 8'h18);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'ha0);
    wb(0, adc_pkg::IDX_CTRL_ONE, 8'h00);
    chk(rd, 32'h0000_0020);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(32'(IRQ), 32'h0000_0000);
    wb(0, adc_pkg::IDX_IRQ_STAT, 8'h00);
    chk(rd, 32'h0000_0001);
    wb(1, adc_pkg::IDX_IRQ_MASK, 8'h01);
    chk(32'(IRQ), 32'h0000_0001);
    wb(0, adc_pkg::IDX_RES_LOW, 8'h00);
    chk(rd, 32'h0000_00e0);
    wb(0, adc_pkg::IDX_RES_UP, 8'h00);
    chk(rd, 32'h0000_00a9);
    wb(0, adc_pkg::IDX_RES_LOW, 8'h00);
    chk(rd, 32'h0000_00c0);
    wb(1, adc_pkg::IDX_IRQ_STAT, 8'h01);
    chk(32'(IRQ), 32'h0000_0000);
    $display("interrupt test done");
  endtask
  task automatic t_repeat;
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'he0);
    repeat (2) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
    wait_busy(1'b1);
    level <= 10'h155;
    repeat (50) @(negedge CLOCK);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h00);
    @(negedge CLOCK);
    chk(32'(BUSY), 32'h0000_0000);
    wb(0, adc_pkg::IDX_RES_UP, 8'h00);
    chk(rd, 32'h0000_00a9);
    wb(0, adc_pkg::IDX_IRQ_STAT, 8'h00);
    chk(rd, 32'h0000_0003);
    wb(1, adc_pkg::IDX_IRQ_STAT, 8'h03);
    $display("repeat test done");
  endtask
  task automatic t_reserved;
    logic [7:0] m [2] = '{8'h80, 8'hc0};
    for (int i = 0; i < 2; i++) begin
      // stop a running repeat conversion with disabled or reserved mode
      wb(1, adc_pkg::IDX_CTRL_ONE, 8'he0);
      wait_busy(1'b1);
      wb(1, adc_pkg::IDX_CTRL_ONE, m[i]);
      repeat (4) @(negedge CLOCK);
      chk(32'(BUSY), 32'h0000_0000);
    end
    $display("reserved mode test done");
  endtask
  task automatic t_low_power;
    wb(1, adc_pkg::IDX_CTRL_TWO, 8'h3c);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'ha5);
    wait_busy(1'b1);
    @(posedge CLOCK);
    LOW_POWER <= 1'b1;
    repeat (6) @(negedge CLOCK);
    chk(32'({BUSY, LADDER_CONNECT}), 32'h0000_0000);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h0b);
    wb(0, adc_pkg::IDX_CTRL_ONE, 8'h00);
    chk(rd, 32'h0000_0010);
    wb(0, adc_pkg::IDX_CTRL_TWO, 8'h00);
    chk(rd & 32'h0000_003f, 32'h0000_0000);
    @(posedge CLOCK);
    LOW_POWER <= 1'b0;
    repeat (4) @(negedge CLOCK);
    wb(1, adc_pkg::IDX_CTRL_ONE, 8'h0b);
    wb(0, adc_pkg::IDX_CTRL_ONE, 8'h00);
    chk(rd, 32'h0000_000b);
    $display("low power test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    RST = 1'b1;
    CYC_I = 1'b0;
    STB_I = 1'b0;
    WE_I = 1'b0;
    ADR_I = 8'h00;
    SEL_I = 4'h1;
    DAT_I = 32'h0000_0000;
    LOW_POWER = 1'b0;
    level = 10'h2a7;
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset;
    t_ctrl;
    t_times;
    t_irq;
    t_repeat;
    t_reserved;
    t_low_power;
    tally_and_finish;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge CLOCK);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
